// File: src/tsrf_pkg.sv
// Package of the temperature-sensor register file: offsets, field positions,
// reset values and the request carriers shared by the design and its bench.
// Assumes a serial slave front end that turns frames into pointer and data strobes.
package tsrf_pkg;

  // Width of every sensor register.
  localparam int unsigned REG_W = 16;
  // Width of the register pointer.
  localparam int unsigned PTR_W = 3;
  // Width of a measured temperature sample, sign included.
  localparam int unsigned TEMP_W = 13;

  // Register pointer values.
  localparam logic [2:0] OFS_CAPABILITY = 3'h0;
  localparam logic [2:0] OFS_CONFIG = 3'h1;
  localparam logic [2:0] OFS_UPPER_LIMIT = 3'h2;
  localparam logic [2:0] OFS_LOWER_LIMIT = 3'h3;
  localparam logic [2:0] OFS_CRIT_LIMIT = 3'h4;
  localparam logic [2:0] OFS_MEASURED = 3'h5;
  localparam logic [2:0] OFS_MAKER_ID = 3'h6;
  localparam logic [2:0] OFS_PART_REV = 3'h7;

  // Pointer value after reset.
  localparam logic [2:0] PTR_RESET = 3'h0;
  // Value of every writable register after reset.
  localparam logic [15:0] WR_RESET = 16'h0000;

  // Configuration field positions.
  localparam int unsigned CFG_MODE_BIT = 0;
  localparam int unsigned CFG_POL_BIT = 1;
  localparam int unsigned CFG_CRIT_ONLY_BIT = 2;
  localparam int unsigned CFG_ENABLE_BIT = 3;
  localparam int unsigned CFG_STATE_BIT = 4;
  localparam int unsigned CFG_CLEAR_BIT = 5;
  localparam int unsigned CFG_ALARM_LOCK_BIT = 6;
  localparam int unsigned CFG_CRIT_LOCK_BIT = 7;
  localparam int unsigned CFG_SHUTDOWN_BIT = 8;
  localparam int unsigned CFG_HYST_LO_BIT = 9;
  localparam int unsigned CFG_HYST_HI_BIT = 10;

  // Capability field positions.
  localparam int unsigned CAP_ALERT_BIT = 0;
  localparam int unsigned CAP_ACCURACY_BIT = 1;
  localparam int unsigned CAP_RANGE_BIT = 2;
  localparam int unsigned CAP_RES_LO_BIT = 3;
  localparam int unsigned CAP_RES_HI_BIT = 4;
  localparam int unsigned CAP_GUARD_BIT = 5;
  localparam int unsigned CAP_TIMEOUT_BIT = 6;
  localparam int unsigned CAP_SHUTDOWN_BIT = 7;

  // Measured-temperature flag positions.
  localparam int unsigned MT_LOW_BIT = 13;
  localparam int unsigned MT_HIGH_BIT = 14;
  localparam int unsigned MT_CRIT_BIT = 15;

  // Limit registers keep bits 12 down to 2; the rest read as zero.
  localparam logic [15:0] LIMIT_MASK = 16'h1FFC;

  // Resolution codes of the capability word.
  localparam logic [1:0] RES_9BIT = 2'h0;
  localparam logic [1:0] RES_10BIT = 2'h1;
  localparam logic [1:0] RES_11BIT = 2'h2;
  localparam logic [1:0] RES_12BIT = 2'h3;

  // Host request from the serial front end, all on the core clock.
  typedef struct packed {
    logic ptr_wr;
    logic data_wr;
    logic [2:0] ptr;
    logic [15:0] wdata;
  } tsrf_host_req_type;

  // Finished conversion from the converter.
  typedef struct packed {
    logic valid;
    logic [12:0] value;
  } tsrf_sample_type;

endpackage : tsrf_pkg

// File: src/tsrf_regs.sv
// Register file of the temperature sensor with limit compare and alert pin control.
// Assumes the serial front end and the converter run on clk_in and hand over
// one-cycle strobes; the alert pin is open drain with an external pull-up.
//
// How it works
// - Eight 16-bit registers selected by host pointer.
// - Pointer selects capability word after reset.
// - Fixed pointer values 0 to 7 per register.
// - Writable registers reset to zero.
// - Alert pin disabled after reset until enabled.
// - Temperature compared with three limits drives alert.
// - Limits are two's complement, quarter-degree step.
// - Trip flags show limit relation only.
// - Bits 12:0 hold signed sixteenth-degree temperature.
// - Maker identifier is fixed and read-only.
// - Part and revision word is fixed, read-only.
// - Capability word ignores host writes.
// - Capability bits 15:8 read as zero.
// - Bit 7 reports shutdown effect on alert.
// - Bit 6 reports bus timeout window.
// - Bit 5 reports write-guard voltage statement.
// - Bits 4:3 encode measurement resolution.
// - Bit 2 reports negative temperature support.
// - Bit 1 reports accuracy class.
// - Bit 0 reports alarm window support.
// - During shutdown, clear bit may clear alert state.
// - Host reads and writes all three limits.
// - Clear bit acts in interrupt mode, reads zero.
`timescale 1ns/1ps

module tsrf_regs #(
  // Capability straps.
  parameter logic SHUTDOWN_CLEARS = 1'b1,
  parameter logic TIMEOUT_NARROW = 1'b1,
  parameter logic GUARD_STATED = 1'b0,
  parameter logic [1:0] RESOLUTION = tsrf_pkg::RES_12BIT,
  parameter logic NEG_RANGE = 1'b1,
  parameter logic ACCURACY_TIGHT = 1'b1,
  parameter logic ALARM_WINDOW = 1'b1,
  // Identification words; the values are arbitrary.
  parameter logic [15:0] MAKER_ID = 16'h00A5,
  parameter logic [15:0] PART_REV = 16'h0100
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire tsrf_pkg::tsrf_host_req_type host_req_in,
  input wire tsrf_pkg::tsrf_sample_type sample_in,
  output logic [2:0] pointer_out,
  output logic [15:0] rd_data_out,
  output logic alert_pin_out,
  output logic alert_pin_oe_n_out
);

  // Register pointer.
  logic [2:0] ptr_r;
  // Configuration bits that are stored (state and clear bits are not).
  logic [15:0] cfg_r;
  // Limit registers.
  logic [15:0] upper_alarm_limit_r;
  logic [15:0] lower_alarm_limit_r;
  logic [15:0] critical_trip_limit_r;
  // Latest temperature sample.
  logic [12:0] temp_r;
  // Alert state before the enable gate.
  logic alert_state_r;
  // Previous event condition, for edge detection in interrupt mode.
  logic cond_prev_r;
  // Read data and pin registers.
  logic [15:0] rd_data_r;
  logic alert_pin_r;
  logic alert_oe_n_r;

  // Write decode: a data write lands on the register the pointer selects.
  wire wr_cfg = host_req_in.data_wr && (ptr_r == tsrf_pkg::OFS_CONFIG);
  wire wr_upper = host_req_in.data_wr && (ptr_r == tsrf_pkg::OFS_UPPER_LIMIT);
  wire wr_lower = host_req_in.data_wr && (ptr_r == tsrf_pkg::OFS_LOWER_LIMIT);
  wire wr_crit = host_req_in.data_wr && (ptr_r == tsrf_pkg::OFS_CRIT_LIMIT);
  wire [15:0] wd = host_req_in.wdata;

  // Configuration fields.
  wire mode_irq = cfg_r[tsrf_pkg::CFG_MODE_BIT];
  wire pol_high = cfg_r[tsrf_pkg::CFG_POL_BIT];
  wire crit_only = cfg_r[tsrf_pkg::CFG_CRIT_ONLY_BIT];
  wire alert_en = cfg_r[tsrf_pkg::CFG_ENABLE_BIT];
  wire alarm_lock = cfg_r[tsrf_pkg::CFG_ALARM_LOCK_BIT];
  wire crit_lock = cfg_r[tsrf_pkg::CFG_CRIT_LOCK_BIT];
  wire shutdown = cfg_r[tsrf_pkg::CFG_SHUTDOWN_BIT];
  wire any_lock = alarm_lock | crit_lock;

  // Next configuration: lock bits only set, guarded fields frozen by any lock.
  wire lock_crit_nxt = crit_lock | (wr_cfg & wd[tsrf_pkg::CFG_CRIT_LOCK_BIT]);
  wire lock_alarm_nxt = alarm_lock | (wr_cfg & wd[tsrf_pkg::CFG_ALARM_LOCK_BIT]);
  wire guarded_wr = wr_cfg & ~any_lock;
  wire [1:0] hyst_nxt = guarded_wr ?
    wd[tsrf_pkg::CFG_HYST_HI_BIT:tsrf_pkg::CFG_HYST_LO_BIT] :
    cfg_r[tsrf_pkg::CFG_HYST_HI_BIT:tsrf_pkg::CFG_HYST_LO_BIT];
  wire mode_nxt = guarded_wr ? wd[tsrf_pkg::CFG_MODE_BIT] : mode_irq;
  wire pol_nxt = guarded_wr ? wd[tsrf_pkg::CFG_POL_BIT] : pol_high;
  wire en_nxt = guarded_wr ? wd[tsrf_pkg::CFG_ENABLE_BIT] : alert_en;
  // Shutdown may be cleared at any time but set only without a lock.
  wire sensor_shutdown_req = wd[tsrf_pkg::CFG_SHUTDOWN_BIT];
  wire sensor_shutdown_nxt = wr_cfg ? (sensor_shutdown_req & (shutdown | ~any_lock)) : shutdown;
  // Critical-only may be cleared at any time but set only without the alarm lock.
  wire conly_req = wd[tsrf_pkg::CFG_CRIT_ONLY_BIT];
  wire conly_nxt = wr_cfg ? (conly_req & (crit_only | ~alarm_lock)) : crit_only;
  wire [15:0] cfg_nxt = {5'h00, hyst_nxt, sensor_shutdown_nxt, lock_crit_nxt, lock_alarm_nxt,
                         2'h0, en_nxt, conly_nxt, pol_nxt, mode_nxt};

  // Limit comparisons on the signed temperature scale.
  wire signed [12:0] temp_s = temp_r;
  wire signed [12:0] upper_s = upper_alarm_limit_r[12:0];
  wire signed [12:0] lower_s = lower_alarm_limit_r[12:0];
  wire signed [12:0] crit_s = critical_trip_limit_r[12:0];
  wire above_crit = temp_s >= crit_s;
  wire above_upper = temp_s > upper_s;
  wire below_lower = temp_s < lower_s;
  // Event condition, optionally restricted to the critical limit.
  wire event_cond = crit_only ? above_crit : (above_crit | above_upper | below_lower);

  // Clear strobe: the clear bit is a write-only action.
  wire clear_wr = wr_cfg & wd[tsrf_pkg::CFG_CLEAR_BIT];
  // Shutdown entry, used to drop the alert state when the strap says so.
  wire sensor_shutdown_entry = sensor_shutdown_nxt & ~shutdown;
  // Rising event condition, the latch source in interrupt mode.
  wire event_rise = event_cond & ~cond_prev_r;

  // Next alert state. A new event wins over a clear in the same cycle.
  wire state_irq_nxt = event_rise | (alert_state_r & ~(clear_wr & ~above_crit));
  wire state_run_nxt = mode_irq ? state_irq_nxt : event_cond;
  wire state_sensor_shutdown_nxt = alert_state_r & ~clear_wr;
  wire alert_state_nxt = (sensor_shutdown_entry & SHUTDOWN_CLEARS) ? 1'b0 :
                         shutdown ? state_sensor_shutdown_nxt : state_run_nxt;
  // Visible state is gated by the output enable.
  wire alert_visible = alert_en & alert_state_r;

  // Limit values keep only the quarter-degree field.
  wire [15:0] limit_wd = wd & tsrf_pkg::LIMIT_MASK;

  // Resolution mask clears sample bits finer than the reported resolution.
  wire [12:0] res_mask = (RESOLUTION == tsrf_pkg::RES_9BIT) ? 13'h1FF8 :
                         (RESOLUTION == tsrf_pkg::RES_10BIT) ? 13'h1FFC :
                         (RESOLUTION == tsrf_pkg::RES_11BIT) ? 13'h1FFE : 13'h1FFF;

  // Capability word built from straps, upper byte zero.
  wire [15:0] capability_word = {8'h00, SHUTDOWN_CLEARS, TIMEOUT_NARROW, GUARD_STATED,
                                 RESOLUTION, NEG_RANGE, ACCURACY_TIGHT, ALARM_WINDOW};

  // Measured-temperature word: trip flags over the signed sample.
  wire [15:0] measured_temp_reg = {above_crit, above_upper, below_lower, temp_r};

  // Configuration as read: stored bits plus the enable-gated alert state, clear bit reads zero.
  wire [15:0] cfg_read = cfg_r | {11'h000, alert_visible, 4'h0};

  // Read multiplexer over the eight registers.
  logic [15:0] rd_mux;
  always_comb
  begin
    case (ptr_r)
      tsrf_pkg::OFS_CAPABILITY: rd_mux = capability_word;
      tsrf_pkg::OFS_CONFIG: rd_mux = cfg_read;
      tsrf_pkg::OFS_UPPER_LIMIT: rd_mux = upper_alarm_limit_r;
      tsrf_pkg::OFS_LOWER_LIMIT: rd_mux = lower_alarm_limit_r;
      tsrf_pkg::OFS_CRIT_LIMIT: rd_mux = critical_trip_limit_r;
      tsrf_pkg::OFS_MEASURED: rd_mux = measured_temp_reg;
      tsrf_pkg::OFS_MAKER_ID: rd_mux = MAKER_ID;
      tsrf_pkg::OFS_PART_REV: rd_mux = PART_REV;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Pin drive: pulled low when the alert is visible and the active level is low, or when the pin is
  // idle under high polarity; released otherwise so the pull-up gives a high.
  wire pin_drive = pol_high ? ~alert_visible : alert_visible;

  // Pointer register, loaded by the front end's pointer strobe.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      ptr_r <= tsrf_pkg::PTR_RESET;
    else if (host_req_in.ptr_wr)
      ptr_r <= host_req_in.ptr;
  end

  // Configuration register; lock bits clear only here at reset.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      cfg_r <= tsrf_pkg::WR_RESET;
    else
      cfg_r <= cfg_nxt;
  end

  // Alarm limits, frozen by the alarm lock.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      upper_alarm_limit_r <= tsrf_pkg::WR_RESET;
      lower_alarm_limit_r <= tsrf_pkg::WR_RESET;
    end
    else
    begin
      if (wr_upper && !alarm_lock)
        upper_alarm_limit_r <= limit_wd;
      if (wr_lower && !alarm_lock)
        lower_alarm_limit_r <= limit_wd;
    end
  end

  // Critical limit, frozen by the critical lock.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      critical_trip_limit_r <= tsrf_pkg::WR_RESET;
    else if (wr_crit && !crit_lock)
      critical_trip_limit_r <= limit_wd;
  end

  // Temperature sample; held while shut down so the last reading stays.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      temp_r <= 13'h0000;
    else if (sample_in.valid && !shutdown)
      temp_r <= sample_in.value & res_mask;
  end

  // Alert state and the condition history for edge detection.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      alert_state_r <= 1'b0;
      cond_prev_r <= 1'b0;
    end
    else
    begin
      alert_state_r <= alert_state_nxt;
      cond_prev_r <= event_cond;
    end
  end

  // Read data register; writes to read-only pointers have no target at all.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rd_data_r <= 16'h0000;
    else
      rd_data_r <= rd_mux;
  end

  // Open-drain pin registers; released during reset with the alert disabled.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      alert_pin_r <= 1'b0;
      alert_oe_n_r <= 1'b1;
    end
    else
    begin
      alert_pin_r <= 1'b0;
      alert_oe_n_r <= ~pin_drive;
    end
  end

  // Outputs straight from flip-flops.
  assign pointer_out = ptr_r;
  assign rd_data_out = rd_data_r;
  assign alert_pin_out = alert_pin_r;
  assign alert_pin_oe_n_out = alert_oe_n_r;

endmodule : tsrf_regs

// File: testbench/tb_top.sv
// Testbench of the sensor register file: register reads and writes, samples, alert pin.
// Assumes the host model drives requests and this bench drives converter samples.
`timescale 1ns/1ps

module tb_top;
  // Identity words; the values are arbitrary.
  localparam logic [15:0] MAKER = 16'h5A5A;
  localparam logic [15:0] PART = 16'h0201;
  // Capability word worked out from the straps given below.
  localparam logic [15:0] CAP = 16'h006F;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  tsrf_pkg::tsrf_host_req_type host_req;
  tsrf_pkg::tsrf_sample_type sample_r = '0;
  logic [2:0] pointer;
  logic [15:0] rd_data;
  logic pin;
  logic pin_oe_n;
  int num_errors = 0;
  int samples_checked = 0;
  // Read-only registers and their expected words.
  logic [2:0] ro_ofs [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
  logic [15:0] ro_exp [4] = '{CAP, 16'h8000, MAKER, PART};
  // Limit writes: upper, lower, critical.
  logic [15:0] lim_wr [3] = '{16'hE193, 16'h0053, 16'h0320};
  // Samples and the expected measured word at quarter-degree resolution.
  logic [12:0] tv [4] = '{13'h0173, 13'h1FF3, 13'h0201, 13'h0322};
  logic [15:0] te [4] = '{16'h0170, 16'h3FF0, 16'h4200, 16'hC320};

  always #5 clk_in = ~clk_in;

  tsrf_host_model u_tsrf_host_model (.clk_in(clk_in), .host_req_out(host_req));

  tsrf_regs #(.SHUTDOWN_CLEARS(1'b0), .GUARD_STATED(1'b1),
    .RESOLUTION(tsrf_pkg::RES_10BIT), .MAKER_ID(MAKER), .PART_REV(PART)) u_tsrf_regs (
    .clk_in(clk_in), .resetn_in(resetn_in), .host_req_in(host_req), .sample_in(sample_r),
    .pointer_out(pointer), .rd_data_out(rd_data), .alert_pin_out(pin),
    .alert_pin_oe_n_out(pin_oe_n));

  // Compares one word and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Lets the pin register settle, then compares its enable.
  task automatic pin_is(input logic e);
    repeat (3) @(posedge clk_in);
    #1;
    chk({15'h0000, pin_oe_n}, {15'h0000, e});
  endtask : pin_is

  // Points at a register and compares the word it shows two edges later.
  task automatic rd(input logic [2:0] p, input logic [15:0] e);
    u_tsrf_host_model.put(1'b1, 1'b0, p, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1;
    chk({13'h0000, pointer}, {13'h0000, p});
    chk(rd_data, e);
  endtask : rd

  // Hands one conversion result over for one cycle, then waits for the flags.
  task automatic temp(input logic [12:0] v);
    @(posedge clk_in);
    sample_r <= '{valid: 1'b1, value: v};
    @(posedge clk_in);
    sample_r <= '{valid: 1'b0, value: ~v};
    repeat (3) @(posedge clk_in);
  endtask : temp

  // Holds reset for twelve cycles, then reads without loading the pointer.
  task automatic rst();
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk(rd_data, CAP);
  endtask : rst

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // Main sequence.
  initial
  begin
    rst();
    for (int i = 1; i < 5; i++)
      rd(3'(i), 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      u_tsrf_host_model.write_word(ro_ofs[i], 16'hFFFF);
      rd(ro_ofs[i], ro_exp[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      u_tsrf_host_model.write_word(3'(i + 2), lim_wr[i]);
      rd(3'(i + 2), lim_wr[i] & 16'h1FFC);
    end
    for (int i = 0; i < 4; i++)
    begin
      temp(tv[i]);
      rd(3'h5, te[i]);
    end
    pin_is(1'b1);
    u_tsrf_host_model.write_word(3'h1, 16'h0008);
    pin_is(1'b0);
    rd(3'h1, 16'h0018);
    temp(13'h0173);
    pin_is(1'b1);
    u_tsrf_host_model.write_word(3'h1, 16'h0009);
    temp(13'h0201);
    rd(3'h1, 16'h0019);
    u_tsrf_host_model.write_word(3'h1, 16'h0109);
    rd(3'h1, 16'h0119);
    temp(13'h0000);
    rd(3'h5, 16'h4200);
    u_tsrf_host_model.write_word(3'h1, 16'h0129);
    rd(3'h1, 16'h0109);
    pin_is(1'b1);
    // High polarity with the output disabled grounds the pin.
    u_tsrf_host_model.write_word(3'h1, 16'h0002);
    pin_is(1'b0);
    // The alarm lock freezes the upper limit until the next reset.
    u_tsrf_host_model.write_word(3'h1, 16'h0040);
    rd(3'h1, 16'h0040);
    u_tsrf_host_model.write_word(3'h2, 16'h0000);
    rd(3'h2, 16'h0190);
    rst();
    rd(3'h2, 16'h0000);
    conclude();
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk_in);
    num_errors++;
    conclude();
  end
endmodule : tb_top

// File: testbench/tsrf_host_model.sv
// Host master model: turns pointer loads and word writes into strobes.
// Assumes the register file takes one-cycle strobes at the rising edge.
`timescale 1ns/1ps

module tsrf_host_model (
  input wire logic clk_in,
  output tsrf_pkg::tsrf_host_req_type host_req_out
);
  // Request register; released fields carry the inverse of the last value.
  tsrf_pkg::tsrf_host_req_type req_r = '0;
  assign host_req_out = req_r;

  // Raises one request for one cycle, then releases it.
  task automatic put(input logic pw, input logic dw, input logic [2:0] p, input logic [15:0] d);
    @(posedge clk_in);
    req_r <= '{ptr_wr: pw, data_wr: dw, ptr: p, wdata: d};
    @(posedge clk_in);
    req_r <= '{ptr_wr: 1'b0, data_wr: 1'b0, ptr: ~p, wdata: ~d};
  endtask : put

  // Loads the pointer first, then writes the word, so data never hits an old pointer.
  task automatic write_word(input logic [2:0] p, input logic [15:0] d);
    put(1'b1, 1'b0, p, d);
    put(1'b0, 1'b1, p, d);
  endtask : write_word
endmodule : tsrf_host_model

// File: testbench/tsrf_regs_props.sv
// Port checker of the sensor register file.
// Assumes it is bound to tsrf_regs and sees only its ports.
`timescale 1ns/1ps

module tsrf_regs_props (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire tsrf_pkg::tsrf_host_req_type host_req_in,
  input wire tsrf_pkg::tsrf_sample_type sample_in,
  input wire logic [2:0] pointer_out,
  input wire logic [15:0] rd_data_out,
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe_n_out
);
  // Every check samples on the core clock and rests in reset.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  AST_PTR_RST: assert property ($rose(resetn_in) |-> pointer_out == 3'h0)
    else $error("pointer not at capability after reset");
  AST_PTR_LOAD: assert property (host_req_in.ptr_wr |=> pointer_out == $past(host_req_in.ptr))
    else $error("pointer did not load");
  AST_PIN_OFF: assert property ($rose(resetn_in) |-> alert_pin_oe_n_out [*2])
    else $error("alert pin driven right after reset");
  AST_PIN_LOW: assert property (alert_pin_out == 1'b0)
    else $error("alert pin data not low");
  AST_CAP_HI: assert property ($past(pointer_out) == 3'h0 |-> rd_data_out[15:8] == 8'h00)
    else $error("capability upper byte not zero");
  AST_RO_STABLE: assert property ($past(resetn_in) && pointer_out inside {3'h0, 3'h6, 3'h7}
    && $past(pointer_out) == pointer_out |=> $stable(rd_data_out))
    else $error("fixed register changed");
  AST_LIMIT_MASK: assert property ($past(pointer_out) inside {3'h2, 3'h3, 3'h4}
    |-> (rd_data_out & 16'hE003) == 16'h0000)
    else $error("limit unused bits not zero");
  AST_CFG_ZERO: assert property ($past(pointer_out) == 3'h1
    |-> rd_data_out[5] == 1'b0 && rd_data_out[15:11] == 5'h00)
    else $error("config clear or reserved bits not zero");

  // Main traffic: configuration writes, samples and a driven pin.
  cover property (host_req_in.data_wr && pointer_out == 3'h1);
  cover property (sample_in.valid);
  cover property ($fell(alert_pin_oe_n_out));
endmodule : tsrf_regs_props

bind tsrf_regs tsrf_regs_props u_tsrf_regs_props (
  .clk_in(clk_in), .resetn_in(resetn_in), .host_req_in(host_req_in),
  .sample_in(sample_in), .pointer_out(pointer_out), .rd_data_out(rd_data_out),
  .alert_pin_out(alert_pin_out), .alert_pin_oe_n_out(alert_pin_oe_n_out));
